// ### common/crx_regs.vh
// Purpose: constants for the acceptance mask and buffer control block
// Assumes: word-indexed register port, 16-bit data
// Notes: addresses are word indices on the plain register port
`ifndef CRX_REGS_VH
`define CRX_REGS_VH

`define CRX_NBUF 32
`define CRX_NFILT 16
`define CRX_ADDR_W 5
`define CRX_DATA_W 16

// register map
`define CRX_ADDR_MSK0_STD 5'h00
`define CRX_ADDR_MSK0_EXT 5'h01
`define CRX_ADDR_MSK1_STD 5'h02
`define CRX_ADDR_MSK1_EXT 5'h03
`define CRX_ADDR_MSK2_STD 5'h04
`define CRX_ADDR_MSK2_EXT 5'h05
`define CRX_ADDR_FULL_LO 5'h06
`define CRX_ADDR_FULL_HI 5'h07
`define CRX_ADDR_OVF_LO 5'h08
`define CRX_ADDR_OVF_HI 5'h09
`define CRX_ADDR_CTRL0 5'h10

// standard-id mask register fields
`define CRX_MSK_SID_MSB 15
`define CRX_MSK_SID_LSB 5
`define CRX_MSK_MODE_BIT 3
`define CRX_MSK_EIDHI_MSB 1
`define CRX_MSK_EIDHI_LSB 0

// buffer control byte fields
`define CRX_CTL_DIR 7
`define CRX_CTL_ABT 6
`define CRX_CTL_LARB 5
`define CRX_CTL_ERR 4
`define CRX_CTL_REQ 3
`define CRX_CTL_AUTO_REMOTE_REPLY_ENABLE 2
`define CRX_CTL_PRI_MSB 1
`define CRX_CTL_PRI_LSB 0

// mask select codes
`define CRX_MSEL_M0 2'h0
`define CRX_MSEL_M1 2'h1
`define CRX_MSEL_RSVD 2'h3

// reset values
`define CRX_RST_16 16'h0000
`define CRX_RST_32 32'h00000000
`define CRX_RST_SID 11'h000
`define CRX_RST_EID 18'h00000
`define CRX_RST_PRI 2'h0
`define CRX_RST_BUF 5'h00
`define CRX_RST_FILT 4'h0

`endif

// ### design/crx_mask_txctl.v
// Purpose: acceptance masking, rx full/overflow flags and tx/rx buffer pair control
// Assumes: single clock, synchronous inputs, message contents live in DMA RAM outside
// Notes: filters, bit engine and DMA engine sit outside and talk over plain ports
`timescale 1ns/1ps
`include "crx_regs.vh"

module crx_mask_txctl (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // register port
    input wire [`CRX_ADDR_W-1:0] reg_addr_i,
    input wire [`CRX_DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [`CRX_DATA_W-1:0] reg_rdata_o,
    // filter bank settings
    input wire [`CRX_NFILT*11-1:0] filter_standard_identifier_i,
    input wire [`CRX_NFILT*18-1:0] filter_extended_identifier_i,
    input wire [`CRX_NFILT-1:0] filter_extended_select_i,
    input wire [`CRX_NFILT*2-1:0] filter_mask_select_i,
    input wire [`CRX_NFILT-1:0] filter_enable_i,
    // received frame header from bit engine
    input wire rx_frame_valid_i,
    input wire [10:0] rx_standard_identifier_i,
    input wire [17:0] rx_extended_identifier_i,
    input wire rx_extended_frame_i,
    output reg rx_accept_o,
    output reg [3:0] rx_accept_filter_o,
    // buffer store and remote frame events from DMA side
    input wire rx_store_i,
    input wire [4:0] rx_store_buf_i,
    input wire rx_remote_hit_i,
    input wire [4:0] rx_remote_buf_i,
    // transmit engine
    output reg tx_select_valid_o,
    output reg [4:0] tx_select_buf_o,
    output wire [`CRX_NBUF-1:0] tx_abort_request_o,
    input wire tx_done_i,
    input wire tx_aborted_i,
    input wire tx_arb_lost_i,
    input wire tx_bus_error_i,
    input wire [4:0] tx_event_buf_i
);

    // acceptance masks, three sets
    reg [10:0] msk_std [0:2];
    reg [17:0] msk_ext [0:2];
    reg [2:0] msk_mode;

    reg [`CRX_NBUF-1:0] rx_buffer_full_flag;
    reg [`CRX_NBUF-1:0] rx_buffer_overflow_flag;
    wire [`CRX_NBUF*8-1:0] ctl_flat;
    wire [`CRX_NBUF-1:0] pending;
    wire [`CRX_NFILT-1:0] filt_hit;

    reg next_accept;
    reg [3:0] next_filter;
    reg next_sel_valid;
    reg [4:0] next_sel_buf;
    reg [1:0] best_pri;
    reg [`CRX_DATA_W-1:0] next_rdata;
    integer i;

    wire wr_msk0s = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK0_STD);
    wire wr_msk1s = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK1_STD);
    wire wr_msk2s = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK2_STD);
    wire wr_msk0e = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK0_EXT);
    wire wr_msk1e = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK1_EXT);
    wire wr_msk2e = reg_wr_i && (reg_addr_i == `CRX_ADDR_MSK2_EXT);
    wire [`CRX_NBUF-1:0] full_clr_sel = {
        {16{reg_wr_i && (reg_addr_i == `CRX_ADDR_FULL_HI)}},
        {16{reg_wr_i && (reg_addr_i == `CRX_ADDR_FULL_LO)}}};
    wire [`CRX_NBUF-1:0] ovf_clr_sel = {
        {16{reg_wr_i && (reg_addr_i == `CRX_ADDR_OVF_HI)}},
        {16{reg_wr_i && (reg_addr_i == `CRX_ADDR_OVF_LO)}}};
    wire [`CRX_NBUF-1:0] wdata_dup = {reg_wdata_i, reg_wdata_i};

    // mask registers; the extended bits are split over two words
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            msk_std[0] <= `CRX_RST_SID;
            msk_std[1] <= `CRX_RST_SID;
            msk_std[2] <= `CRX_RST_SID;
            msk_ext[0] <= `CRX_RST_EID;
            msk_ext[1] <= `CRX_RST_EID;
            msk_ext[2] <= `CRX_RST_EID;
            msk_mode <= 3'h0;
        end
        else
        begin
            if (wr_msk0s)
            begin
                msk_std[0] <= reg_wdata_i[`CRX_MSK_SID_MSB:`CRX_MSK_SID_LSB];
                msk_mode[0] <= reg_wdata_i[`CRX_MSK_MODE_BIT];
                msk_ext[0][17:16] <= reg_wdata_i[`CRX_MSK_EIDHI_MSB:`CRX_MSK_EIDHI_LSB];
            end
            if (wr_msk1s)
            begin
                msk_std[1] <= reg_wdata_i[`CRX_MSK_SID_MSB:`CRX_MSK_SID_LSB];
                msk_mode[1] <= reg_wdata_i[`CRX_MSK_MODE_BIT];
                msk_ext[1][17:16] <= reg_wdata_i[`CRX_MSK_EIDHI_MSB:`CRX_MSK_EIDHI_LSB];
            end
            if (wr_msk2s)
            begin
                msk_std[2] <= reg_wdata_i[`CRX_MSK_SID_MSB:`CRX_MSK_SID_LSB];
                msk_mode[2] <= reg_wdata_i[`CRX_MSK_MODE_BIT];
                msk_ext[2][17:16] <= reg_wdata_i[`CRX_MSK_EIDHI_MSB:`CRX_MSK_EIDHI_LSB];
            end
            if (wr_msk0e)
                msk_ext[0][15:0] <= reg_wdata_i;
            if (wr_msk1e)
                msk_ext[1][15:0] <= reg_wdata_i;
            if (wr_msk2e)
                msk_ext[2][15:0] <= reg_wdata_i;
        end
    end

    genvar g;

    // per-filter comparison against the selected mask
    generate
        for (g = 0; g < `CRX_NFILT; g = g + 1)
        begin : g_filt
            wire [1:0] sel = filter_mask_select_i[2*g +: 2];
            wire [10:0] f_std = filter_standard_identifier_i[11*g +: 11];
            wire [17:0] f_ext = filter_extended_identifier_i[18*g +: 18];
            // code 11 falls through to mask 2 in these muxes; filt_hit drops it
            wire [10:0] m_std = (sel == `CRX_MSEL_M0) ? msk_std[0] :
                                (sel == `CRX_MSEL_M1) ? msk_std[1] : msk_std[2];
            wire [17:0] m_ext = (sel == `CRX_MSEL_M0) ? msk_ext[0] :
                                (sel == `CRX_MSEL_M1) ? msk_ext[1] : msk_ext[2];
            wire m_mode = (sel == `CRX_MSEL_M0) ? msk_mode[0] :
                          (sel == `CRX_MSEL_M1) ? msk_mode[1] : msk_mode[2];
            // a cleared mask bit drops out of the xor compare
            wire std_ok = ~|((f_std ^ rx_standard_identifier_i) & m_std);
            wire ext_ok = ~|((f_ext ^ rx_extended_identifier_i) & m_ext);
            wire type_ok = filter_extended_select_i[g] == rx_extended_frame_i;
            // extended frames need the full id; standard ones only the 11 bits
            wire id_ok = rx_extended_frame_i ? (std_ok && ext_ok) : std_ok;
            wire strict = type_ok && id_ok;
            wire loose = id_ok;
            // reserved select code never matches rather than guessing a mask
            assign filt_hit[g] = filter_enable_i[g] && (sel != `CRX_MSEL_RSVD) &&
                                 (m_mode ? strict : loose);
        end
    endgenerate

    // lowest-numbered hit wins: scan downward so low indices overwrite
    always @*
    begin
        next_accept = 1'b0;
        next_filter = `CRX_RST_FILT;
        for (i = `CRX_NFILT - 1; i >= 0; i = i - 1)
        begin
            if (filt_hit[i])
            begin
                next_accept = 1'b1;
                next_filter = i[3:0];
            end
        end
    end

    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_accept_o <= 1'b0;
            rx_accept_filter_o <= `CRX_RST_FILT;
        end
        else
        begin
            rx_accept_o <= rx_frame_valid_i && next_accept;
            // index holds after the pulse so it can be picked up late
            if (rx_frame_valid_i && next_accept)
                rx_accept_filter_o <= next_filter;
        end
    end

    // per-buffer flags and control byte
    generate
        for (g = 0; g < `CRX_NBUF; g = g + 1)
        begin : g_buf
            localparam integer BUF_IDX = g;
            localparam integer CTL_IDX = g / 2;
            localparam [4:0] BUF_ID = BUF_IDX[4:0];
            localparam [`CRX_ADDR_W-1:0] CTL_ADDR = `CRX_ADDR_CTRL0 + CTL_IDX[4:0];
            localparam LANE = (g % 2) * 8;
            wire ctl_wr = reg_wr_i && (reg_addr_i == CTL_ADDR);
            wire [7:0] wb = reg_wdata_i[LANE +: 8];
            wire store_hit = rx_store_i && (rx_store_buf_i == BUF_ID);
            wire evt_hit = tx_event_buf_i == BUF_ID;

            reg dir;
            reg abt;
            reg larb;
            reg err;
            reg req;
            reg auto_remote_reply_enable;
            reg [1:0] pri;
            reg abort_req;

            // a word write touches both buffers: rewriting a partner byte
            // with its request bit low aborts that partner's pending send
            wire sw_set = ctl_wr && wb[`CRX_CTL_REQ];
            wire sw_abort = ctl_wr && !wb[`CRX_CTL_REQ] && req;
            wire rtr_set = rx_remote_hit_i && (rx_remote_buf_i == BUF_ID) && auto_remote_reply_enable && dir;
            wire req_set = sw_set || rtr_set;
            wire done_hit = tx_done_i && evt_hit;
            wire abt_hit = tx_aborted_i && evt_hit;

            // hardware set wins over a software clear in the same cycle
            // a store into a full buffer keeps full set and raises overflow
            always @(posedge ref_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    rx_buffer_full_flag[g] <= 1'b0;
                    rx_buffer_overflow_flag[g] <= 1'b0;
                end
                else
                begin
                    rx_buffer_full_flag[g] <= store_hit ||
                        (rx_buffer_full_flag[g] && !(full_clr_sel[g] && !wdata_dup[g]));
                    rx_buffer_overflow_flag[g] <= (store_hit && rx_buffer_full_flag[g]) ||
                        (rx_buffer_overflow_flag[g] && !(ovf_clr_sel[g] && !wdata_dup[g]));
                end
            end

            always @(posedge ref_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    dir <= 1'b0;
                    abt <= 1'b0;
                    larb <= 1'b0;
                    err <= 1'b0;
                    req <= 1'b0;
                    auto_remote_reply_enable <= 1'b0;
                    pri <= `CRX_RST_PRI;
                    abort_req <= 1'b0;
                end
                else
                begin
                    // flag bits of wb are never looked at
                    if (ctl_wr)
                    begin
                        dir <= wb[`CRX_CTL_DIR];
                        auto_remote_reply_enable <= wb[`CRX_CTL_AUTO_REMOTE_REPLY_ENABLE];
                        pri <= wb[`CRX_CTL_PRI_MSB:`CRX_CTL_PRI_LSB];
                    end
                    // a new request must win over a completion of the old one
                    if (req_set)
                        req <= 1'b1;
                    else if (done_hit || abt_hit)
                        req <= 1'b0;
                    // the request stays up until the engine reports this buffer done or aborted, or a new request is set
                    if (req_set || done_hit || abt_hit)
                        abort_req <= 1'b0;
                    else if (sw_abort)
                        abort_req <= 1'b1;
                    // an event in the same cycle as a new request keeps its flag
                    abt <= abt_hit || (abt && !req_set);
                    larb <= (tx_arb_lost_i && evt_hit) || (larb && !req_set);
                    err <= (tx_bus_error_i && evt_hit) || (err && !req_set);
                end
            end

            // one packed view shared by the read mux and the priority scan
            assign ctl_flat[8*g +: 8] = {dir, abt, larb, err, req, auto_remote_reply_enable, pri};
            assign pending[g] = dir && req && !abort_req;
            assign tx_abort_request_o[g] = abort_req;
        end
    endgenerate

    // highest priority pending buffer; ties go to the lowest index
    // plain scan every cycle: no state to go stale, at the cost of depth
    always @*
    begin
        next_sel_valid = 1'b0;
        next_sel_buf = `CRX_RST_BUF;
        best_pri = `CRX_RST_PRI;
        for (i = `CRX_NBUF - 1; i >= 0; i = i - 1)
        begin
            if (pending[i] && (!next_sel_valid ||
                ctl_flat[8*i+`CRX_CTL_PRI_LSB +: 2] >= best_pri))
            begin
                next_sel_valid = 1'b1;
                next_sel_buf = i[4:0];
                best_pri = ctl_flat[8*i+`CRX_CTL_PRI_LSB +: 2];
            end
        end
    end

    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_select_valid_o <= 1'b0;
            tx_select_buf_o <= `CRX_RST_BUF;
        end
        else
        begin
            // registered so the engine never sees a half-settled choice
            tx_select_valid_o <= next_sel_valid;
            tx_select_buf_o <= next_sel_buf;
        end
    end

    // read mux; message contents are not here but in DMA RAM
    always @*
    begin
        next_rdata = `CRX_RST_16;
        case (reg_addr_i)
            `CRX_ADDR_MSK0_STD: next_rdata = {msk_std[0], 1'b0, msk_mode[0], 1'b0, msk_ext[0][17:16]};
            `CRX_ADDR_MSK1_STD: next_rdata = {msk_std[1], 1'b0, msk_mode[1], 1'b0, msk_ext[1][17:16]};
            `CRX_ADDR_MSK2_STD: next_rdata = {msk_std[2], 1'b0, msk_mode[2], 1'b0, msk_ext[2][17:16]};
            `CRX_ADDR_MSK0_EXT: next_rdata = msk_ext[0][15:0];
            `CRX_ADDR_MSK1_EXT: next_rdata = msk_ext[1][15:0];
            `CRX_ADDR_MSK2_EXT: next_rdata = msk_ext[2][15:0];
            `CRX_ADDR_FULL_LO: next_rdata = rx_buffer_full_flag[15:0];
            `CRX_ADDR_FULL_HI: next_rdata = rx_buffer_full_flag[31:16];
            `CRX_ADDR_OVF_LO: next_rdata = rx_buffer_overflow_flag[15:0];
            `CRX_ADDR_OVF_HI: next_rdata = rx_buffer_overflow_flag[31:16];
            default:
            begin
                if (reg_addr_i >= `CRX_ADDR_CTRL0)
                    next_rdata = ctl_flat[16*(reg_addr_i - `CRX_ADDR_CTRL0) +: 16];
                else
                    next_rdata = `CRX_RST_16;
            end
        endcase
    end

    // read data only in the cycle after the strobe, zero otherwise
    // zero between reads so a stale word never passes for fresh data
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= `CRX_RST_16;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
        else
            reg_rdata_o <= `CRX_RST_16;
    end

endmodule

// ### test/crx_mask_txctl_chk.sv
// Purpose: port checks for crx_mask_txctl
// Assumes: one clock, reset low and asynchronous
// Notes: bound into the design below
`timescale 1ns/1ps
`include "crx_regs.vh"
module crx_mask_txctl_chk (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // register port
    input wire [4:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [15:0] reg_rdata_o,
    // receive side
    input wire rx_frame_valid_i,
    input wire rx_accept_o,
    input wire [3:0] rx_accept_filter_o,
    input wire rx_store_i,
    input wire [4:0] rx_store_buf_i,
    input wire rx_remote_hit_i,
    // transmit side
    input wire tx_select_valid_o,
    input wire [4:0] tx_select_buf_o,
    input wire [31:0] tx_abort_request_o,
    input wire tx_done_i,
    input wire tx_aborted_i,
    input wire [4:0] tx_event_buf_i
);
    reg [4:0] sb_q;
    reg [4:0] sb_q2;
    reg [4:0] ev_q;
    reg [4:0] ev_q2;
    // delayed buffer numbers so a later cycle can index by them
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sb_q <= 5'h00;
            sb_q2 <= 5'h00;
            ev_q <= 5'h00;
            ev_q2 <= 5'h00;
        end
        else
        begin
            sb_q <= rx_store_buf_i;
            sb_q2 <= sb_q;
            ev_q <= tx_event_buf_i;
            ev_q2 <= ev_q;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_store_read;
        rx_store_i ##1 reg_rd_i && reg_addr_i == (sb_q[4] ? `CRX_ADDR_FULL_HI : `CRX_ADDR_FULL_LO);
    endsequence
    sequence s_done_settle;
        tx_done_i ##2 1'b1;
    endsequence
    a_read_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside read slot");
    a_mask_unimpl_zero: assert property (reg_rd_i && reg_addr_i < 5'h06 && !reg_addr_i[0]
        |=> (reg_rdata_o[4] | reg_rdata_o[2]) == 1'b0) else $error("unused mask bits not zero");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 5'h09 && reg_addr_i < 5'h10
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_full_after_store: assert property (s_store_read |=> reg_rdata_o[sb_q2[3:0]])
        else $error("full flag not set after store");
    a_accept_cause: assert property (rx_accept_o |-> $past(rx_frame_valid_i))
        else $error("accept without frame");
    a_filter_idx_hold: assert property (!rx_accept_o |-> $stable(rx_accept_filter_o))
        else $error("filter index moved without accept");
    a_abort_req_drop: assert property (tx_aborted_i |=> !tx_abort_request_o[ev_q])
        else $error("abort request kept after abort");
    a_abort_req_cause: assert property ((tx_abort_request_o & ~$past(tx_abort_request_o)) != 32'h0
        |-> $past(reg_wr_i) && $past(reg_addr_i) >= 5'h10) else $error("abort request without write");
    a_select_cause: assert property ($rose(tx_select_valid_o)
        |-> $past(reg_wr_i, 2) || $past(rx_remote_hit_i, 2)) else $error("select without request");
    a_done_deselect: assert property (s_done_settle |-> !(tx_select_valid_o && tx_select_buf_o == ev_q2))
        else $error("sent buffer still selected");
endmodule
bind crx_mask_txctl crx_mask_txctl_chk i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
    .rx_frame_valid_i(rx_frame_valid_i), .rx_accept_o(rx_accept_o), .rx_accept_filter_o(rx_accept_filter_o),
    .rx_store_i(rx_store_i), .rx_store_buf_i(rx_store_buf_i), .rx_remote_hit_i(rx_remote_hit_i),
    .tx_select_valid_o(tx_select_valid_o), .tx_select_buf_o(tx_select_buf_o),
    .tx_abort_request_o(tx_abort_request_o), .tx_done_i(tx_done_i), .tx_aborted_i(tx_aborted_i),
    .tx_event_buf_i(tx_event_buf_i));

// ### test/crx_bus_node.sv
// Purpose: transmit engine and bus model facing the buffer control
// Assumes: picks up the selected buffer when idle
// Notes: faults only when the bench asks for them
`timescale 1ns/1ps
module crx_bus_node (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // from the design
    input wire sel_valid_i,
    input wire [4:0] sel_buf_i,
    input wire [31:0] abort_req_i,
    // scenario control: 1 lose arbitration, 2 bus error
    input wire [1:0] fault_i,
    input wire slow_i,
    // events back
    output reg done_o,
    output reg aborted_o,
    output reg arb_lost_o,
    output reg bus_error_o,
    output reg [4:0] event_buf_o
);
    reg busy;
    reg [2:0] cnt;
    reg [1:0] gap;
    reg [4:0] cur;
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            {busy, cnt, gap, cur} <= 11'h000;
            {done_o, aborted_o, arb_lost_o, bus_error_o} <= 4'h0;
            event_buf_o <= 5'h00;
        end
        else
        begin
            {done_o, aborted_o, arb_lost_o, bus_error_o} <= 4'h0;
            // between events the buffer id flips to its complement each cycle, so the last id comes back every other cycle
            event_buf_o <= ~event_buf_o;
            if (busy && cnt != 3'h0)
                cnt <= cnt - 3'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                gap <= 2'h3;
                event_buf_o <= cur;
                if (abort_req_i[cur])
                    aborted_o <= 1'b1;
                else if (fault_i == 2'h1)
                    arb_lost_o <= 1'b1;
                else if (fault_i == 2'h2)
                    bus_error_o <= 1'b1;
                else
                    done_o <= 1'b1;
            end
            // wait for the select to settle after an event
            else if (gap != 2'h0)
                gap <= gap - 2'h1;
            else if (sel_valid_i)
            begin
                busy <= 1'b1;
                cur <= sel_buf_i;
                cnt <= slow_i ? 3'h6 : 3'h0;
            end
        end
    end
endmodule

// ### test/crx_mask_txctl_tb_top.sv
// Purpose: self-checking bench for crx_mask_txctl
// Assumes: bus node model on the transmit side
// Notes: random masks and filters from a fixed seed
`timescale 1ns/1ps
`include "crx_regs.vh"
module crx_mask_txctl_tb_top;
    reg clk = 0, rst_b = 0, wr = 0, rd_s = 0, vld = 0, rx_x = 0, sto = 0, hit = 0, slow = 1;
    reg [4:0] adr = 0, sbuf = 0, hbuf = 0;
    reg [15:0] wd = 0, fx = 0, fen = 0;
    reg [175:0] fsid = 0;
    reg [287:0] feid = 0;
    reg [31:0] fms = 0, sh_full = 0, sh_ovf = 0;
    reg [10:0] rsid = 0;
    reg [17:0] reid = 0;
    reg [1:0] fault = 0;
    reg [15:0] ms [0:2];
    reg [15:0] me [0:2];
    reg [4:0] e;
    wire [15:0] rdat;
    wire acc, sel_v, done, abt, arb, berr;
    wire [3:0] acc_f;
    wire [4:0] sel_b, ebuf;
    wire [31:0] abreq;
    integer seed = 32'hca3096c3, bad_count = 0, n_compared = 0, i, k;
    crx_mask_txctl i_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd_s), .reg_rdata_o(rdat), .filter_standard_identifier_i(fsid), .filter_extended_identifier_i(feid),
        .filter_extended_select_i(fx), .filter_mask_select_i(fms), .filter_enable_i(fen), .rx_frame_valid_i(vld),
        .rx_standard_identifier_i(rsid), .rx_extended_identifier_i(reid), .rx_extended_frame_i(rx_x),
        .rx_accept_o(acc), .rx_accept_filter_o(acc_f), .rx_store_i(sto), .rx_store_buf_i(sbuf), .rx_remote_hit_i(hit),
        .rx_remote_buf_i(hbuf), .tx_select_valid_o(sel_v), .tx_select_buf_o(sel_b), .tx_abort_request_o(abreq),
        .tx_done_i(done), .tx_aborted_i(abt), .tx_arb_lost_i(arb), .tx_bus_error_i(berr), .tx_event_buf_i(ebuf));
    crx_bus_node i_node (.ref_clk_i(clk), .rst_b_i(rst_b), .sel_valid_i(sel_v), .sel_buf_i(sel_b), .abort_req_i(abreq),
        .fault_i(fault), .slow_i(slow), .done_o(done), .aborted_o(abt), .arb_lost_o(arb), .bus_error_o(berr),
        .event_buf_o(ebuf));
    initial forever #12.5 clk = ~clk;
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task print_verdict;
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task bus(input w, input [4:0] a, input [15:0] d);
        @(posedge clk);
        {wr, rd_s} <= {w, !w};
        adr <= a;
        wd <= d;
        @(posedge clk);
        {wr, rd_s} <= 2'h0;
        @(negedge clk);
    endtask
    task rd(input [4:0] a, input [15:0] x, input string nm);
        bus(0, a, 16'h0000);
        chk(nm, rdat, x);
    endtask
    task store(input [4:0] b);
        sh_ovf[b] = sh_ovf[b] | sh_full[b];
        sh_full[b] = 1'b1;
        @(posedge clk);
        sto <= 1'b1;
        sbuf <= b;
        @(posedge clk);
        sto <= 1'b0;
        rd_s <= 1'b1;
        adr <= b[4] ? `CRX_ADDR_FULL_HI : `CRX_ADDR_FULL_LO;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk("full flag", rdat[b[3:0]], 16'h0001);
    endtask
    task remote(input [4:0] b);
        @(posedge clk);
        hit <= 1'b1;
        hbuf <= b;
        @(posedge clk);
        hit <= 1'b0;
    endtask
    task wait_ev;
        for (k = 0; k < 200 && !(done | abt | arb | berr); k++)
            @(negedge clk);
        chk("tx event", k < 200, 16'h0001);
        @(negedge clk);
    endtask
    // lowest enabled filter that matches under its selected mask
    function [4:0] exp_hit(input [10:0] s, input [17:0] x, input ext);
        integer f;
        reg [15:0] m;
        exp_hit = 5'h00;
        for (f = 15; f >= 0; f--)
        begin
            m = ms[fms[2*f+:2]];
            if (fen[f] && fms[2*f+:2] != 2'h3 && (m[15:5] & (s ^ fsid[11*f+:11])) == 11'h000 && (!m[3] || ext == fx[f])
                && (!ext || ({m[1:0], me[fms[2*f+:2]]} & (x ^ feid[18*f+:18])) == 18'h00000))
                exp_hit = {1'b1, f[3:0]};
        end
    endfunction
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 11; i++)
            rd(i == 10 ? 5'h10 : 5'(i), 16'h0000, "reset value");
        bus(1, 5'h0C, 16'hFFFF);
        rd(5'h0C, 16'h0000, "unmapped");
        for (k = 0; k < 40; k++)
        begin
            for (i = 0; i < 3; i++)
            begin
                ms[i] = $random(seed) & $random(seed);
                me[i] = $random(seed) & $random(seed);
                bus(1, 5'(2 * i), ms[i]);
                bus(1, 5'(2 * i + 1), me[i]);
                rd(5'(2 * i), ms[i] & 16'hFFEB, "mask std");
            end
            @(posedge clk);
            for (i = 0; i < 16; i++)
                {fsid[11*i+:11], feid[18*i+:18]} <= {$random(seed), $random(seed)};
            {fx, fen, fms} <= {$random(seed), $random(seed), $random(seed)};
            @(posedge clk);
            i = $random(seed) & 15;
            rsid <= fsid[11*i+:11] ^ ($random(seed) & $random(seed) & $random(seed));
            reid <= feid[18*i+:18] ^ ($random(seed) & $random(seed) & $random(seed));
            rx_x <= $random(seed);
            vld <= 1'b1;
            @(posedge clk);
            vld <= 1'b0;
            @(negedge clk);
            e = exp_hit(rsid, reid, rx_x);
            chk("accept", acc, e[4]);
            if (e[4])
                chk("filter index", acc_f, e[3:0]);
        end
        for (k = 0; k < 24; k++)
            store(k < 2 ? 5'h03 : 5'($random(seed)));
        bus(1, `CRX_ADDR_FULL_LO, 16'hFFF7);
        sh_full[3] = 1'b0;
        bus(1, `CRX_ADDR_OVF_HI, 16'h0000);
        sh_ovf[31:16] = 16'h0000;
        for (i = 0; i < 4; i++)
            rd(5'h06 + 5'(i), i[1] ? sh_ovf[16*i[0]+:16] : sh_full[16*i[0]+:16], "flags");
        bus(1, 5'h10, 16'h7777);
        rd(5'h10, 16'h0707, "ctl readback");
        bus(1, 5'h11, 16'h8A89);
        @(negedge clk);
        chk("selected", sel_b, 16'h0003);
        wait_ev;
        wait_ev;
        rd(5'h11, 16'h8281, "sent");
        for (i = 1; i < 3; i++)
        begin
            @(posedge clk);
            fault <= 2'(i);
            bus(1, 5'h12, 16'h0088);
            rd(5'h12, 16'h0088, "flags cleared");
            wait_ev;
            @(posedge clk);
            fault <= 2'h0;
            rd(5'h12, i == 1 ? 16'h00A8 : 16'h0098, "fault flag");
            wait_ev;
        end
        bus(1, 5'h12, 16'h8880);
        bus(1, 5'h12, 16'h8080);
        wait_ev;
        rd(5'h12, 16'hC090, "aborted");
        @(posedge clk);
        slow <= 1'b0;
        bus(1, 5'h13, 16'h8084);
        remote(5'h07);
        repeat (3) @(negedge clk);
        chk("no auto reply", sel_v, 16'h0000);
        remote(5'h06);
        wait_ev;
        rd(5'h13, 16'h8084, "auto reply");
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict;
    end
endmodule
